//--- src/cal_top.sv
// Channel assessment and link quality block with APB register access.
// Assumes radio front end supplies energy, carrier and correlation samples synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
`include "cal_defines.svh"

// Contract
// - Per frame quality byte 0..255 from correlation
// - Quality valid only for payloads of two octets or more
// - Quality byte appended after frame in buffer
// - Byte available once frame-end interrupt raised
// - Mode field bits 6:5, reset one
// - Mode one: busy on energy above threshold
// - Mode two: busy on conformant carrier only
// - Mode three: carrier and energy both needed
// - Threshold is base plus two dB per step
// - Trigger write starts measurement in receive states
// - Eight symbols evaluated, result after 140 us
// - Completion flag bit 7 zero while busy
// - Idle flag bit 6 one when channel idle
// - Status read clears completion and idle flags
// - Carrier sense busy above base sensitivity level
// - Status bits 7,6, reserved 5, state 4:0
// - Control: trigger 7, mode 6:5, channel 4:0
// - Base sensitivity level is minus 91 dBm
module cal_top (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Transceiver state and receive context
	input  wire logic [4:0]  trx_state,
	input  wire logic        rx_state_active,
	// Front-end samples
	input  wire logic [7:0]  energy_db,
	input  wire logic        carrier_seen,
	// Frame reception
	input  wire logic        frame_start,
	input  wire logic        frame_end,
	input  wire logic        corr_valid,
	input  wire logic [7:0]  corr_value,
	input  wire logic [7:0]  frame_len,
	// Frame buffer append port
	output logic             fb_wr_en,
	output logic      [7:0]  fb_wr_addr,
	output logic      [7:0]  fb_wr_data,
	// Frame-end event and assessment results
	output logic             frame_end_interrupt,
	output logic             lqi_valid_out,
	output logic      [4:0]  channel_out,
	output logic             assess_busy
);
	// Register state
	logic [1:0]  mode_ff;
	logic [4:0]  chan_ff;
	logic [3:0]  thr_ff;
	logic [3:0]  thr_rsvd_ff;
	logic        done_ff;
	logic        idle_ff;
	logic [7:0]  lqi_ff;
	cal_pkg::cal_state_t state_ff;
	logic [10:0] tmr_ff;
	logic        busy_seen_ff;
	// Outputs held in flip-flops
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        fb_wr_en_ff;
	logic [7:0]  fb_wr_addr_ff;
	logic [7:0]  fb_wr_data_ff;
	logic        irq_ff;
	logic        lqi_valid_ff;
	logic        assess_busy_ff;
	// Combinational
	logic        setup;
	logic        wr_req;
	logic        rd_req;
	logic        hit;
	logic        sample_busy;
	logic        trig;
	logic        rd_status;
	logic [7:0]  calc_lqi;
	logic        calc_valid;
	logic        calc_strobe;
	logic [7:0]  nxt_rdata;
	logic        sel_status;
	logic        sel_control;
	logic        sel_thresh;
	logic        eval_end;
	logic        result_due;

	// Address decode shared by read and write paths
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `CAL_ADDR_STATUS) || (a == `CAL_ADDR_CONTROL) ||
			(a == `CAL_ADDR_THRESH) || (a == `CAL_ADDR_LQI);
	endfunction : is_mapped

	// Register select from a printed index; byte address is four times the index
	function automatic logic reg_at(input logic [11:0] a, input logic [7:0] idx);
		reg_at = (a == {2'b00, idx, 2'b00});
	endfunction : reg_at

	// Register selects shared by the write, trigger and clear paths
	assign sel_status  = reg_at(paddr, `CAL_IDX_STATUS);
	assign sel_control = reg_at(paddr, `CAL_IDX_CONTROL);
	assign sel_thresh  = reg_at(paddr, `CAL_IDX_THRESH);

	// Zero-wait-state APB: setup registers the answer, access completes
	assign setup  = psel && !penable && !pready_ff;
	assign wr_req = setup && pwrite;
	assign rd_req = setup && !pwrite;
	assign hit    = is_mapped(paddr);

	// Trigger accepted only in receive states and only when not already running
	assign trig = wr_req && sel_control && pwdata[`CAL_CTL_TRIG_BIT]
		&& rx_state_active && (state_ff == cal_pkg::CAL_IDLE);
	assign rd_status = rd_req && sel_status;

	// Sequencer milestones: end of the sampling window and result due
	assign eval_end   = (state_ff == cal_pkg::CAL_EVAL) && (tmr_ff == 11'(`CAL_EVAL_CYC));
	assign result_due = (state_ff == cal_pkg::CAL_WAIT) && (tmr_ff == 11'(`CAL_RESULT_CYC));

	cal_busy_judge u_judge (
		.mode         (mode_ff),
		.thresh       (thr_ff),
		.energy_db    (energy_db),
		.carrier_seen (carrier_seen),
		.busy         (sample_busy)
	);

	cal_lqi_calc u_lqi (
		.clock       (clock),
		.reset_n     (reset_n),
		.frame_start (frame_start),
		.frame_end   (frame_end),
		.corr_valid  (corr_valid),
		.corr_value  (corr_value),
		.frame_len   (frame_len),
		.lqi         (calc_lqi),
		.lqi_valid   (calc_valid),
		.lqi_strobe  (calc_strobe)
	);

	// Read data mux
	always_comb begin
		case (paddr)
			`CAL_ADDR_STATUS:  nxt_rdata = {done_ff, idle_ff, 1'b0, trx_state};
			`CAL_ADDR_CONTROL: nxt_rdata = {1'b0, mode_ff, chan_ff};
			`CAL_ADDR_THRESH:  nxt_rdata = {thr_rsvd_ff, thr_ff};
			`CAL_ADDR_LQI:     nxt_rdata = lqi_ff;
			default:           nxt_rdata = 8'h00;
		endcase
	end

	// APB handshake: ready one cycle after setup, error on unmapped address
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup && !hit;
		end
	end

	// APB read data: captured at setup, held until the next read
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			prdata_ff <= 32'h0000_0000;
		end else if (rd_req) begin
			prdata_ff <= {24'h00_0000, nxt_rdata};
		end
	end

	// Control register; the trigger bit is never stored and reads back as zero
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mode_ff <= 2'(`CAL_CTL_RESET >> `CAL_CTL_MODE_LSB);
			chan_ff <= 5'(`CAL_CTL_RESET);
		end else if (wr_req && sel_control) begin
			mode_ff <= pwdata[`CAL_CTL_MODE_MSB:`CAL_CTL_MODE_LSB];
			chan_ff <= pwdata[`CAL_CTL_CHAN_MSB:0];
		end
	end

	// Threshold register; the upper nibble is kept but has no effect
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			thr_ff      <= 4'(`CAL_THR_RESET);
			thr_rsvd_ff <= 4'(`CAL_THR_RESET >> 4);
		end else if (wr_req && sel_thresh) begin
			thr_ff      <= pwdata[3:0];
			thr_rsvd_ff <= pwdata[7:4];
		end
	end

	// Assessment sequencer: sample eight symbols, then wait out the result latency
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_ff <= cal_pkg::CAL_IDLE;
		end else begin
			case (state_ff)
				cal_pkg::CAL_IDLE: begin
					if (trig) begin
						state_ff <= cal_pkg::CAL_EVAL;
					end
				end
				cal_pkg::CAL_EVAL: begin
					if (eval_end) begin
						state_ff <= cal_pkg::CAL_WAIT;
					end
				end
				cal_pkg::CAL_WAIT: begin
					if (result_due) begin
						state_ff <= cal_pkg::CAL_IDLE;
					end
				end
				default: begin
					state_ff <= cal_pkg::CAL_IDLE;
				end
			endcase
		end
	end

	// Cycle timer counted from the trigger edge, so the result is due a fixed time after it
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tmr_ff <= 11'h000;
		end else if (trig) begin
			tmr_ff <= 11'h001;
		end else if (result_due) begin
			tmr_ff <= 11'h000;
		end else if (state_ff != cal_pkg::CAL_IDLE) begin
			tmr_ff <= tmr_ff + 11'h001;
		end
	end

	// Busy memory: one busy sample in the window marks the channel busy
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busy_seen_ff <= 1'b0;
		end else if (trig) begin
			busy_seen_ff <= 1'b0;
		end else if (state_ff == cal_pkg::CAL_EVAL) begin
			busy_seen_ff <= busy_seen_ff | sample_busy;
		end
	end

	// Busy port mirrors the sequencer from a flip-flop of its own
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			assess_busy_ff <= 1'b0;
		end else if (trig) begin
			assess_busy_ff <= 1'b1;
		end else if (result_due) begin
			assess_busy_ff <= 1'b0;
		end
	end

	// Completion flag: finishing wins over a status read in the same cycle
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			done_ff <= 1'b0;
		end else if (result_due) begin
			done_ff <= 1'b1;
		end else if (trig || rd_status) begin
			done_ff <= 1'b0;
		end
	end

	// Idle flag: set with completion when no busy sample was seen
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			idle_ff <= 1'b0;
		end else if (result_due) begin
			idle_ff <= !busy_seen_ff;
		end else if (trig || rd_status) begin
			idle_ff <= 1'b0;
		end
	end

	// Quality register readable over APB, replaced at each frame end
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			lqi_ff       <= 8'h00;
			lqi_valid_ff <= 1'b0;
		end else if (calc_strobe) begin
			lqi_ff       <= calc_lqi;
			lqi_valid_ff <= calc_valid;
		end
	end

	// Buffer write of the quality byte just after the payload
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			fb_wr_en_ff   <= 1'b0;
			fb_wr_addr_ff <= 8'h00;
			fb_wr_data_ff <= 8'h00;
		end else begin
			fb_wr_en_ff <= calc_strobe;
			if (calc_strobe) begin
				fb_wr_addr_ff <= frame_len;
				fb_wr_data_ff <= calc_lqi;
			end
		end
	end

	// Frame-end event raised only once the byte is in the buffer
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= fb_wr_en_ff;
		end
	end

	assign prdata              = prdata_ff;
	assign pready              = pready_ff;
	assign pslverr             = pslverr_ff;
	assign fb_wr_en            = fb_wr_en_ff;
	assign fb_wr_addr          = fb_wr_addr_ff;
	assign fb_wr_data          = fb_wr_data_ff;
	assign frame_end_interrupt = irq_ff;
	assign lqi_valid_out       = lqi_valid_ff;
	assign channel_out         = chan_ff;
	assign assess_busy         = assess_busy_ff;
endmodule : cal_top
`default_nettype wire

//--- src/cal_defines.svh
// Constants of the channel assessment and link quality block: offsets, fields, resets, timing.
// Assumes a 10 MHz core clock and 32-bit APB with one register per aligned word.
`ifndef CAL_DEFINES_SVH
`define CAL_DEFINES_SVH

// Register indices as printed; byte address is four times the index
`define CAL_IDX_STATUS        8'h01
`define CAL_IDX_CONTROL       8'h08
`define CAL_IDX_THRESH        8'h09
`define CAL_IDX_LQI           8'h0a
// Byte addresses
`define CAL_ADDR_STATUS       12'h004
`define CAL_ADDR_CONTROL      12'h020
`define CAL_ADDR_THRESH       12'h024
`define CAL_ADDR_LQI          12'h028

// Status fields
`define CAL_ST_DONE_BIT       7
`define CAL_ST_IDLE_BIT       6
`define CAL_ST_STATE_MSB      4
// Control fields
`define CAL_CTL_TRIG_BIT      7
`define CAL_CTL_MODE_MSB      6
`define CAL_CTL_MODE_LSB      5
`define CAL_CTL_CHAN_MSB      4
// Reset values
`define CAL_CTL_RESET         8'h2b
`define CAL_THR_RESET         8'hc7

// Base sensitivity level in dBm and threshold step in dB
`define CAL_BASE_DBM          (-91)
`define CAL_THR_STEP_DB       2

// Timing: result latency and evaluation window
`define CAL_CLK_MHZ           10
`define CAL_RESULT_US         140
`define CAL_RESULT_CYC        (`CAL_RESULT_US * `CAL_CLK_MHZ)
`define CAL_SYMBOL_US         16
`define CAL_EVAL_SYMBOLS      8
`define CAL_EVAL_CYC          (`CAL_SYMBOL_US * `CAL_EVAL_SYMBOLS * `CAL_CLK_MHZ)

// Minimum payload for a valid quality byte
`define CAL_LQI_MIN_LEN       8'h02

`endif

//--- src/cal_pkg.sv
// Types of the channel assessment and link quality block.
// Assumes cal_defines.svh supplies all numeric constants.
package cal_pkg;
	typedef enum logic [1:0] {
		CAL_MODE_RSVD,
		CAL_MODE_ENERGY,
		CAL_MODE_CARRIER,
		CAL_MODE_BOTH
	} cal_mode_t;

	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_EVAL,
		CAL_WAIT
	} cal_state_t;
endpackage : cal_pkg

//--- src/cal_busy_judge.sv
// Busy judgement of one energy and carrier sample under the selected mode.
// Assumes energy is given in dB above the base sensitivity level.
`timescale 1ns/1ns
`default_nettype none
`include "cal_defines.svh"

module cal_busy_judge (
	// Selection
	input  wire logic [1:0] mode,
	input  wire logic [3:0] thresh,
	// Sample
	input  wire logic [7:0] energy_db,
	input  wire logic       carrier_seen,
	// Verdict
	output logic            busy
);
	logic [7:0] limit_db;
	logic       above;

	// Threshold is base level plus two dB per step
	assign limit_db = 8'(`CAL_THR_STEP_DB) * {4'h0, thresh};
	assign above = energy_db > limit_db;

	// Mode decode
	always_comb begin
		case (cal_pkg::cal_mode_t'(mode))
			cal_pkg::CAL_MODE_ENERGY:  busy = above;
			cal_pkg::CAL_MODE_CARRIER: busy = carrier_seen;
			cal_pkg::CAL_MODE_BOTH:    busy = carrier_seen & above;
			default:                   busy = 1'b0;                 // Reserved mode never busy
		endcase
	end
endmodule : cal_busy_judge
`default_nettype wire

//--- src/cal_lqi_calc.sv
// Link quality accumulator: averages per-symbol correlation over one frame.
// Assumes corr_valid pulses once per symbol between frame_start and frame_end.
`timescale 1ns/1ns
`default_nettype none
`include "cal_defines.svh"

module cal_lqi_calc (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// Frame events
	input  wire logic       frame_start,
	input  wire logic       frame_end,
	input  wire logic       corr_valid,
	input  wire logic [7:0] corr_value,
	input  wire logic [7:0] frame_len,
	// Result
	output logic [7:0]      lqi,
	output logic            lqi_valid,
	output logic            lqi_strobe
);
	logic [15:0] sum_ff;
	logic [7:0]  cnt_ff;
	logic [7:0]  lqi_ff;
	logic        valid_ff;
	logic        strobe_ff;

	// Running sum of correlation over the frame's symbols
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sum_ff <= 16'h0000;
			cnt_ff <= 8'h00;
		end else if (frame_start) begin
			sum_ff <= 16'h0000;
			cnt_ff <= 8'h00;
		end else if (corr_valid && cnt_ff != 8'hff) begin
			sum_ff <= sum_ff + {8'h00, corr_value};
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	// Mean over symbols, always within 0 to 255
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			lqi_ff    <= 8'h00;
			valid_ff  <= 1'b0;
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= frame_end;
			if (frame_end) begin
				lqi_ff   <= (cnt_ff == 8'h00) ? 8'h00 : 8'(sum_ff / {8'h00, cnt_ff});
				valid_ff <= frame_len >= `CAL_LQI_MIN_LEN;
			end
		end
	end

	assign lqi        = lqi_ff;
	assign lqi_valid  = valid_ff;
	assign lqi_strobe = strobe_ff;
endmodule : cal_lqi_calc
`default_nettype wire

//--- verif/cal_top_monitor.sv
// Checker of the assessment and quality block, watching top-level ports only.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "cal_defines.svh"
module cal_top_monitor (
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Receive context
	input wire logic [4:0]  trx_state,
	input wire logic        rx_state_active,
	// Frame side
	input wire logic        frame_end,
	input wire logic [7:0]  frame_len,
	input wire logic        fb_wr_en,
	input wire logic [7:0]  fb_wr_addr,
	input wire logic        frame_end_interrupt,
	input wire logic        lqi_valid_out,
	input wire logic        assess_busy
);
	logic [10:0] busy_cnt_ff;
	logic        trig;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Trigger write seen in the setup cycle
	assign trig = psel && !penable && pwrite && paddr == `CAL_ADDR_CONTROL && pwdata[7] && !assess_busy;

	// Cycles spent in the current assessment
	always_ff @(posedge clock) begin
		if (!reset_n || !assess_busy)
			busy_cnt_ff <= 11'h000;
		else
			busy_cnt_ff <= busy_cnt_ff + 11'h001;
	end

	AST_APB_ANSWER: assert property (psel && !penable |=> pready && penable)
		else $error("no answer in access phase");
	AST_APB_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_UNMAPPED_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	AST_STATUS_STATE: assert property (pready && !pwrite && paddr == `CAL_ADDR_STATUS
		|-> prdata[31:8] == 24'h0 && prdata[5:0] == {1'b0, $past(trx_state)}) else $error("status layout wrong");
	AST_TRIGGER_START: assert property (trig && rx_state_active |=> assess_busy)
		else $error("trigger did not start");
	AST_TRIGGER_IGNORED: assert property (trig && !rx_state_active |=> !assess_busy)
		else $error("trigger outside receive started");
	AST_RESULT_TIME: assert property ($fell(assess_busy) |-> busy_cnt_ff == 11'(`CAL_RESULT_CYC))
		else $error("assessment length wrong");
	AST_FB_AFTER_END: assert property (frame_end |-> ##2 fb_wr_en)
		else $error("quality byte not written");
	AST_IRQ_AFTER_FB: assert property (fb_wr_en |=> frame_end_interrupt)
		else $error("frame end event late");
	AST_FB_PLACE: assert property (fb_wr_en |-> fb_wr_addr == $past(frame_len, 2)
		&& lqi_valid_out == ($past(frame_len, 2) >= 8'h02)) else $error("quality byte place or validity wrong");

	// Main scenarios reached
	COV_ASSESS: cover property ($fell(assess_busy));
	COV_FRAME: cover property (frame_end_interrupt);
	COV_REFUSED: cover property (pready && pslverr);
endmodule : cal_top_monitor

bind cal_top cal_top_monitor i_cal_top_monitor (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.trx_state(trx_state), .rx_state_active(rx_state_active), .frame_end(frame_end), .frame_len(frame_len),
	.fb_wr_en(fb_wr_en), .fb_wr_addr(fb_wr_addr), .frame_end_interrupt(frame_end_interrupt),
	.lqi_valid_out(lqi_valid_out), .assess_busy(assess_busy));
`default_nettype wire

//--- verif/cal_host_model.sv
// Host model: APB master issuing single register transfers.
// Assumes the bench calls xfer and the slave answers with pready.
`timescale 1ns/1ns
`default_nettype none
module cal_host_model (
	// Clock
	input  wire logic        clock,
	// Request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	// Answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Bus idle at time zero
	initial {psel, penable, pwrite, paddr, pwdata} = '0;

	// One transfer; setup cycle, then access held until pready, answer sampled with pready
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clock);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a; // Released lines show junk
		pwdata  <= ~wd;
	endtask : xfer
endmodule : cal_host_model
`default_nettype wire

//--- verif/tb_channel_assess_link_quality.sv
// Self-checking bench of the assessment and quality block.
// Assumes cal_top, the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`include "cal_defines.svh"
module tb_channel_assess_link_quality;
	logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, rx_state_active, carrier_seen, err;
	logic        frame_start, frame_end, corr_valid, fb_wr_en, frame_end_interrupt, lqi_valid_out, assess_busy;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  trx_state, channel_out;
	logic [7:0]  energy_db, corr_value, frame_len, fb_wr_addr, fb_wr_data;
	int          mismatches, checked;

	cal_top i_cal_top (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trx_state(trx_state), .rx_state_active(rx_state_active), .energy_db(energy_db),
		.carrier_seen(carrier_seen), .frame_start(frame_start), .frame_end(frame_end), .corr_valid(corr_valid),
		.corr_value(corr_value), .frame_len(frame_len), .fb_wr_en(fb_wr_en), .fb_wr_addr(fb_wr_addr),
		.fb_wr_data(fb_wr_data), .frame_end_interrupt(frame_end_interrupt), .lqi_valid_out(lqi_valid_out),
		.channel_out(channel_out), .assess_busy(assess_busy));
	cal_host_model i_cal_host_model (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 100 ns clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// Busy verdict of a mode for held energy and carrier
	function automatic logic exp_busy(logic [1:0] m, logic [3:0] t, logic [7:0] e, logic c);
		logic hot;
		hot = e > {3'h0, t, 1'b0};
		return (m == 2'd1 && hot) || (m == 2'd2 && c) || (m == 2'd3 && c && hot);
	endfunction : exp_busy

	// Mean correlation of a frame
	function automatic logic [7:0] exp_lqi(int s, int n);
		return (n == 0) ? 8'h00 : 8'(s / n);
	endfunction : exp_lqi

	// One assessment with energy at or one above the threshold
	task automatic assess(input logic [1:0] m, input logic rx);
		logic [3:0] t;
		logic [7:0] e;
		logic       c;
		logic [4:0] ch, tx;
		t = 4'($urandom);
		e = {3'h0, t, 1'b0} + 8'($urandom_range(1, 0));
		c = 1'($urandom);
		ch = 5'($urandom);
		tx = 5'($urandom);
		energy_db <= e;
		carrier_seen <= c;
		rx_state_active <= rx;
		trx_state <= tx;
		i_cal_host_model.xfer(1'b1, `CAL_ADDR_THRESH, {24'h0, 4'ha, t}, rd, err);
		i_cal_host_model.xfer(1'b0, `CAL_ADDR_THRESH, 32'h0, rd, err);
		chk(rd, {24'h0, 4'ha, t});
		i_cal_host_model.xfer(1'b1, `CAL_ADDR_CONTROL, {24'h0, 1'b1, m, ch}, rd, err);
		if (rx)
			do @(posedge clock); while (assess_busy === 1'b1);
		i_cal_host_model.xfer(1'b0, `CAL_ADDR_STATUS, 32'h0, rd, err);
		chk({24'h0, rd[7], 7'h0}, {24'h0, rx, 7'h0});
		chk({1'b0, rd[31:8], rd[6:0]}, {1'b0, 24'h0, rx && !exp_busy(m, t, e, c), 1'b0, tx});
		i_cal_host_model.xfer(1'b0, `CAL_ADDR_STATUS, 32'h0, rd, err);
		chk(rd, {24'h0, 3'h0, tx});
		i_cal_host_model.xfer(1'b0, `CAL_ADDR_CONTROL, 32'h0, rd, err);
		chk(rd, {24'h0, 1'b0, m, ch});
		chk({27'h0, channel_out}, {27'h0, ch});
	endtask : assess

	// One received frame of n symbols and payload length len
	task automatic frame(input int n, input logic [7:0] len);
		int         s;
		logic [7:0] v;
		s = 0;
		frame_start <= 1'b1;
		frame_len <= len;
		@(posedge clock);
		frame_start <= 1'b0;
		repeat (n) begin
			v = 8'($urandom);
			s += v;
			corr_valid <= 1'b1;
			corr_value <= v;
			@(posedge clock);
		end
		corr_valid <= 1'b0;
		frame_end <= 1'b1;
		@(posedge clock);
		frame_end <= 1'b0;
		do @(posedge clock); while (fb_wr_en !== 1'b1);
		chk({24'h0, fb_wr_data}, {24'h0, exp_lqi(s, n)});
		chk({23'h0, lqi_valid_out, fb_wr_addr}, {23'h0, len >= 8'h02, len});
		do @(posedge clock); while (frame_end_interrupt !== 1'b1);
		i_cal_host_model.xfer(1'b0, `CAL_ADDR_LQI, 32'h0, rd, err);
		chk(rd, {24'h0, exp_lqi(s, n)});
	endtask : frame

	// Main sequence
	initial begin
		{reset_n, rx_state_active, carrier_seen, frame_start, frame_end, corr_valid} = '0;
		{energy_db, corr_value, frame_len, trx_state} = '0;
		mismatches = 0;
		checked = 0;
		void'($urandom(36460));
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		i_cal_host_model.xfer(1'b0, `CAL_ADDR_CONTROL, 32'h0, rd, err);
		chk(rd, 32'h2b);
		i_cal_host_model.xfer(1'b0, `CAL_ADDR_THRESH, 32'h0, rd, err);
		chk(rd, 32'hc7);
		i_cal_host_model.xfer(1'b1, `CAL_ADDR_STATUS, 32'hff, rd, err);
		i_cal_host_model.xfer(1'b0, `CAL_ADDR_STATUS, 32'h0, rd, err);
		chk(rd, 32'h0);
		i_cal_host_model.xfer(1'b0, 12'h100, 32'h0, rd, err);
		chk({err, rd[30:0]}, 32'h80000000);
		for (int m = 0; m < 4; m++)
			assess(2'(m), 1'b1);
		repeat (8) assess(2'($urandom), 1'b1);
		assess(2'd1, 1'b0);
		frame(0, 8'h01);
		frame(1, 8'h02);
		repeat (6) frame($urandom_range(20, 1), 8'($urandom_range(40, 0)));
		tally_and_finish();
	end

	// Watchdog
	initial begin
		#(60000 * 100);
		mismatches++;
		tally_and_finish();
	end
endmodule : tb_channel_assess_link_quality
`default_nettype wire
